/* File: design/sefe_pkg.sv */
// -----------------------------------------------------------------------------
// Shared constants of the serial front end
// -----------------------------------------------------------------------------
package sefe_pkg;
  // Core clock rate in hertz.
  localparam int SEFE_CORE_CLK_HZ = 100_000_000;
  // Longest internal write cycle in milliseconds, and its length in core cycles.
  localparam int SEFE_TWC_MS = 5;
  localparam int SEFE_TWC_CYCLES = SEFE_TWC_MS * (SEFE_CORE_CLK_HZ / 1000);
  // Address width, page size as address bits, and write buffer shape.
  localparam int SEFE_ADDR_W = 8;
  localparam int SEFE_PAGE_BITS = 4;
  localparam int SEFE_FIFO_DEPTH = 32;
  localparam int SEFE_FIFO_WIDTH = 16;
  // Instruction decode: bit 3 of the instruction byte is a don't care.
  localparam logic [7:0] SEFE_OP_MASK = 8'hf7;
  localparam logic [7:0] SEFE_OP_READ = 8'h03;
  localparam logic [7:0] SEFE_OP_WRITE = 8'h02;
  localparam logic [7:0] SEFE_OP_CLR_WRITE_LATCH = 8'h04;
  localparam logic [7:0] SEFE_OP_READ_STATUS = 8'h05;
  localparam logic [7:0] SEFE_OP_SET_WRITE_LATCH = 8'h06;
  // Status byte field positions and the index of the last bit of a byte.
  localparam int SEFE_ST_BUSY_BIT = 0;
  localparam int SEFE_ST_LATCH_BIT = 1;
  localparam logic [2:0] SEFE_LAST_BIT = 3'h7;
  // Reset levels of the synchronised pins.
  localparam logic [1:0] SEFE_SYNC_LOW = 2'h0;
  localparam logic [1:0] SEFE_SYNC_HIGH = 2'h3;

  typedef enum logic [3:0] {
    SEFE_PH_IDLE,
    SEFE_PH_CMD,
    SEFE_PH_RADDR,
    SEFE_PH_WADDR,
    SEFE_PH_RDATA,
    SEFE_PH_WDATA,
    SEFE_PH_STATUS,
    SEFE_PH_DONE,
    SEFE_PH_SKIP
  } sefe_phase_t;
endpackage

/* File: design/sefe_fifo.sv */
`timescale 1ns/1ps
// -----------------------------------------------------------------------------
// Write data buffer
// -----------------------------------------------------------------------------
module sefe_fifo #(
  parameter int WIDTH = sefe_pkg::SEFE_FIFO_WIDTH,
  parameter int DEPTH = sefe_pkg::SEFE_FIFO_DEPTH
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_flush,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  import sefe_pkg::*;

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  wire push = i_in_valid & o_in_ready;
  wire pop = o_out_valid & i_out_ready;

  // Full when the pointers differ only in the wrap bit; DEPTH must be a power of two.
  assign o_in_ready = ~((wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]));
  assign o_out_valid = (wr_ptr != rd_ptr);
  assign o_out_data = mem[rd_ptr[AW-1:0]];

  // Storage carries no reset, so it maps onto plain RAM.
  always_ff @(posedge i_core_clk)
  begin
    if (push)
    begin
      mem[wr_ptr[AW-1:0]] <= i_in_data;
    end
  end

  // Flush drops everything, which is how an aborted write sequence is discarded.
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else if (i_flush)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end
    else
    begin
      wr_ptr <= wr_ptr + (AW+1)'(push);
      rd_ptr <= rd_ptr + (AW+1)'(pop);
    end
  end
endmodule // sefe_fifo

/* File: design/sefe_spi_front.sv */
`timescale 1ns/1ps
// -----------------------------------------------------------------------------
// Serial front end of the byte-wide memory
// -----------------------------------------------------------------------------
module sefe_spi_front #(
  parameter int TWC_CYCLES = sefe_pkg::SEFE_TWC_CYCLES
) (
  input wire logic i_core_clk,
  input wire logic i_resetn,
  input wire logic i_sck,
  input wire logic i_cs_n,
  input wire logic i_hold_n,
  input wire logic i_si,
  output logic o_so,
  output logic o_so_oe_n,
  output logic o_write_busy_flag,
  output logic [sefe_pkg::SEFE_ADDR_W-1:0] o_rd_addr,
  input wire logic [7:0] i_rd_data,
  output logic o_mem_we,
  output logic [sefe_pkg::SEFE_ADDR_W-1:0] o_mem_waddr,
  output logic [7:0] o_mem_wdata,
  input wire logic i_mem_ready
);
  import sefe_pkg::*;

  localparam int CNT_W = $clog2(TWC_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TWC_CYCLES - 1);
  localparam int PB = SEFE_PAGE_BITS;

  function automatic logic op_is(input logic [7:0] b, input logic [7:0] code);
    return (b & SEFE_OP_MASK) == code;
  endfunction

  // ---------------------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ---------------------------------------------------------------------------
  logic [1:0] sck_sy;
  logic [1:0] cs_sy;
  logic [1:0] hold_sy;
  logic [1:0] si_sy;
  logic sck_d;
  logic cs_d;

  // Every pin passes two flops; the serial clock is just another sampled level.
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      sck_sy <= SEFE_SYNC_LOW;
      cs_sy <= SEFE_SYNC_HIGH;
      hold_sy <= SEFE_SYNC_HIGH;
      si_sy <= SEFE_SYNC_LOW;
      sck_d <= 1'b0;
      cs_d <= 1'b1;
    end
    else
    begin
      sck_sy <= {sck_sy[0], i_sck};
      cs_sy <= {cs_sy[0], i_cs_n};
      hold_sy <= {hold_sy[0], i_hold_n};
      si_sy <= {si_sy[0], i_si};
      sck_d <= sck_sy[1];
      cs_d <= cs_sy[1];
    end
  end

  // Clock edges count only while selected and not paused; select is never masked.
  wire cs_s = cs_sy[1];
  wire hold_s = hold_sy[1];
  wire si_s = si_sy[1];
  wire cs_fall = ~cs_s & cs_d;
  wire cs_rise = cs_s & ~cs_d;
  wire active = ~cs_s & ~cs_d & hold_s;
  wire sck_rise = active & sck_sy[1] & ~sck_d;
  wire sck_fall = active & ~sck_sy[1] & sck_d;

  // ---------------------------------------------------------------------------
  // Transfer state
  // ---------------------------------------------------------------------------
  sefe_phase_t phase;
  sefe_phase_t next_phase;
  logic [2:0] bit_cnt;
  logic [7:0] sh;
  logic [7:0] ir;
  logic [SEFE_ADDR_W-1:0] addr;
  logic wel;
  logic busy;
  logic [CNT_W-1:0] busy_cnt;
  logic wrote_any;
  logic overrun;
  logic [7:0] so_sr;
  logic [7:0] status_byte;
  logic f_in_ready;
  logic f_out_valid;
  logic [SEFE_FIFO_WIDTH-1:0] f_out_data;

  // Bits arrive most significant first, so each new bit enters at the bottom.
  wire [7:0] next_sh = {sh[6:0], si_s};
  wire byte_done = sck_rise & (bit_cnt == SEFE_LAST_BIT);
  wire out_phase = (phase == SEFE_PH_RDATA) | (phase == SEFE_PH_STATUS);
  wire wr_push = byte_done & (phase == SEFE_PH_WDATA);
  // A write counts only if select rises on a byte boundary with no data lost.
  wire wr_commit = cs_rise & (phase == SEFE_PH_WDATA) & (bit_cnt == 3'h0)
                   & wrote_any & ~overrun;
  wire wr_abort = cs_rise & (phase == SEFE_PH_WDATA) & ~wr_commit;
  wire busy_end = busy & (busy_cnt == CNT_LAST);
  wire latch_set = cs_rise & (phase == SEFE_PH_DONE) & op_is(ir, SEFE_OP_SET_WRITE_LATCH);
  wire latch_clr = cs_rise & (phase == SEFE_PH_DONE) & op_is(ir, SEFE_OP_CLR_WRITE_LATCH);
  wire mem_pop = busy & f_out_valid & (~o_mem_we | i_mem_ready);
  wire [SEFE_ADDR_W-1:0] page_next = {addr[SEFE_ADDR_W-1:PB], addr[PB-1:0] + PB'(1)};
  wire [7:0] load_byte = (phase == SEFE_PH_STATUS) ? status_byte : i_rd_data;

  // Status byte: the upper bits read as zero.
  always_comb
  begin
    status_byte = 8'h00;
    status_byte[SEFE_ST_BUSY_BIT] = busy;
    status_byte[SEFE_ST_LATCH_BIT] = wel;
  end

  // Phase sequencing; reads are refused while a write cycle runs.
  always_comb
  begin
    next_phase = phase;
    if (cs_fall)
      next_phase = SEFE_PH_CMD;
    else if (cs_s)
      next_phase = SEFE_PH_IDLE;
    else if (byte_done)
    begin
      case (phase)
        SEFE_PH_CMD:
        begin
          // Decode the byte completed by this very edge.
          if (op_is(next_sh, SEFE_OP_READ) && !busy)
            next_phase = SEFE_PH_RADDR;
          else if (op_is(next_sh, SEFE_OP_WRITE) && wel && !busy)
            next_phase = SEFE_PH_WADDR;
          else if (op_is(next_sh, SEFE_OP_READ_STATUS))
            next_phase = SEFE_PH_STATUS;
          else if (op_is(next_sh, SEFE_OP_SET_WRITE_LATCH)
                   || op_is(next_sh, SEFE_OP_CLR_WRITE_LATCH))
            next_phase = SEFE_PH_DONE;
          else
            next_phase = SEFE_PH_SKIP;
        end
        SEFE_PH_RADDR: next_phase = SEFE_PH_RDATA;
        SEFE_PH_WADDR: next_phase = SEFE_PH_WDATA;
        // A further full byte after a latch command spoils it.
        SEFE_PH_DONE: next_phase = SEFE_PH_SKIP;
        default: next_phase = phase;
      endcase
    end
  end

  // While paused no edge is seen, so the bit counter and shift register simply hold their values.
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      phase <= SEFE_PH_IDLE;
      bit_cnt <= 3'h0;
      sh <= 8'h00;
      ir <= 8'h00;
    end
    else
    begin
      phase <= next_phase;
      if (cs_fall)
        bit_cnt <= 3'h0;
      else if (sck_rise)
        bit_cnt <= bit_cnt + 3'h1;
      if (sck_rise)
        sh <= next_sh;
      if (byte_done && phase == SEFE_PH_CMD)
        ir <= next_sh;
    end
  end

  // Address pointer: reads roll over the whole array, writes wrap in the page.
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      addr <= '0;
    else if (byte_done && (phase == SEFE_PH_RADDR || phase == SEFE_PH_WADDR))
      addr <= next_sh;
    else if (byte_done && phase == SEFE_PH_RDATA)
      addr <= addr + SEFE_ADDR_W'(1);
    else if (wr_push)
      addr <= page_next;
  end

  // Write bookkeeping. Bytes past buffer capacity are lost, so the write is vetoed.
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      wrote_any <= 1'b0;
      overrun <= 1'b0;
    end
    else if (cs_fall)
    begin
      wrote_any <= 1'b0;
      overrun <= 1'b0;
    end
    else if (wr_push)
    begin
      wrote_any <= 1'b1;
      overrun <= overrun | ~f_in_ready;
    end
  end

  // Write latch; a latch command set wins over the end-of-write clear.
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
      wel <= 1'b0;
    else if (latch_set)
      wel <= 1'b1;
    else if (latch_clr || busy_end)
      wel <= 1'b0;
  end

  // Self-timed write cycle of fixed length.
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      busy <= 1'b0;
      busy_cnt <= '0;
    end
    else if (wr_commit)
    begin
      busy <= 1'b1;
      busy_cnt <= '0;
    end
    else if (busy_end)
      busy <= 1'b0;
    else if (busy)
      busy_cnt <= busy_cnt + CNT_W'(1);
  end

  // Array write port, one registered stage that waits on the array's ready.
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_mem_we <= 1'b0;
      o_mem_waddr <= '0;
      o_mem_wdata <= 8'h00;
    end
    else if (mem_pop)
    begin
      o_mem_we <= 1'b1;
      o_mem_waddr <= f_out_data[15:8];
      o_mem_wdata <= f_out_data[7:0];
    end
    else if (i_mem_ready)
      o_mem_we <= 1'b0;
  end

  // Output shifter moves on the clock fall so the host samples on the rise.
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      o_so <= 1'b0;
      so_sr <= 8'h00;
      o_so_oe_n <= 1'b1;
    end
    else
    begin
      if (sck_fall && out_phase && bit_cnt == 3'h0)
      begin
        o_so <= load_byte[7];
        so_sr <= {load_byte[6:0], 1'b0};
      end
      else if (sck_fall && out_phase)
      begin
        o_so <= so_sr[7];
        so_sr <= {so_sr[6:0], 1'b0};
      end
      o_so_oe_n <= ~(out_phase & ~cs_s & hold_s);
    end
  end

  assign o_write_busy_flag = busy;
  assign o_rd_addr = addr;

  // Buffer of page bytes, drained to the array during the write cycle.
  sefe_fifo #(
    .WIDTH(SEFE_FIFO_WIDTH),
    .DEPTH(SEFE_FIFO_DEPTH)
  ) u_fifo (
    .i_core_clk(i_core_clk),
    .i_resetn(i_resetn),
    .i_flush(wr_abort | busy_end),
    .i_in_valid(wr_push),
    .o_in_ready(f_in_ready),
    .i_in_data({addr, next_sh}),
    .o_out_valid(f_out_valid),
    .i_out_ready(mem_pop),
    .o_out_data(f_out_data)
  );

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  ir_width_a: assert property (sck_rise && phase == SEFE_PH_CMD && bit_cnt == 3'h7
    |=> phase != SEFE_PH_CMD && ir == $past(next_sh)) else $error("command byte not taken");
  msb_first_a: assert property (sck_rise |=> sh == {$past(sh[6:0]), $past(si_s)})
    else $error("input bit not shifted in at bottom");
  first_bit_a: assert property (cs_fall |=> phase == SEFE_PH_CMD && bit_cnt == 3'h0)
    else $error("select fall did not restart the transfer");
  pause_hold_a: assert property (!hold_s && !cs_s && !cs_d |=> $stable(bit_cnt)
    && $stable(sh) && $stable(so_sr)) else $error("state moved while paused");
  write_start_a: assert property (wr_commit |=> busy && busy_cnt == '0)
    else $error("write cycle did not start");
  write_len_a: assert property (busy_end |=> !busy && wel == $past(latch_set))
    else $error("write cycle overran");
  so_edge_a: assert property ($changed(o_so) |-> $past(sck_fall))
    else $error("serial output changed off clock fall");
  pause_float_a: assert property (!hold_s |=> o_so_oe_n)
    else $error("serial output driven while paused");
  decode_a: assert property (byte_done && phase == SEFE_PH_CMD
    && op_is(next_sh, SEFE_OP_SET_WRITE_LATCH) && !cs_s |=> phase == SEFE_PH_DONE)
    else $error("latch command not decoded");
  latch_set_a: assert property ($rose(wel) |-> $past(phase) == SEFE_PH_DONE
    && $past(cs_rise)) else $error("write latch set off sequence");
  busy_flag_a: assert property ($rose(o_write_busy_flag) |-> $past(wr_commit)
    && status_byte[SEFE_ST_BUSY_BIT]) else $error("busy flag wrong");

  read_byte_c: cover property (byte_done && phase == SEFE_PH_RDATA);
  write_go_c: cover property (wr_commit);
  latch_on_c: cover property (latch_set);
  pause_c: cover property (!hold_s && phase == SEFE_PH_RDATA);
endmodule // sefe_spi_front

/* File: verif/sefe_host_model.sv */
`timescale 1ns/1ps
// -----------------------------------------------------------------------------
// Host controller on the far side of the serial link
// -----------------------------------------------------------------------------
module sefe_host_model (
  input wire logic i_core_clk,
  input wire logic i_so,
  input wire logic i_so_oe_n,
  output logic o_sck,
  output logic o_cs_n,
  output logic o_hold_n,
  output logic o_si
);
  logic [7:0] rx_byte;
  logic paused_oe;
  logic so_last;
  logic so_wire;
  event rx_done;

  // Idle link: select high, pause released, clock still and low.
  initial
  begin
    o_sck = 1'b0;
    o_cs_n = 1'b1;
    o_hold_n = 1'b1;
    o_si = 1'b0;
    so_last = 1'b0;
    paused_oe = 1'b0;
  end

  // A floating output reads as the inverse of its last level, so stale data never matches.
  always @(i_so or i_so_oe_n)
    if (i_so_oe_n === 1'b0)
      so_last = i_so;
  assign so_wire = (i_so_oe_n === 1'b0) ? i_so : ~so_last;

  // Half a link clock period is four core cycles, so the link runs at 80 ns.
  task automatic half_bit();
    repeat (4) @(posedge i_core_clk);
    #1;
  endtask

  task automatic open_frame();
    o_cs_n = 1'b0;
    half_bit();
  endtask

  task automatic close_frame();
    half_bit();
    o_cs_n = 1'b1;
    o_si = ~o_si;
    half_bit();
    half_bit();
  endtask

  // Pause while the clock is low; the clock pulse inside must be ignored.
  // Hold drops half a bit after the clock fall, so that fall is still seen.
  task automatic pause();
    half_bit();
    o_hold_n = 1'b0;
    half_bit();
    o_sck = 1'b1;
    o_si = ~o_si;
    half_bit();
    paused_oe = i_so_oe_n;
    o_sck = 1'b0;
    half_bit();
    o_hold_n = 1'b1;
    half_bit();
  endtask

  // One byte each way; data changes with the falling clock and is sampled on the rise.
  task automatic xfer(input logic [7:0] tx, input int pause_at);
    for (int i = 7; i >= 0; i--)
    begin
      if (i == pause_at)
        pause();
      o_si = tx[i];
      half_bit();
      o_sck = 1'b1;
      rx_byte[i] = so_wire;
      half_bit();
      o_sck = 1'b0;
    end
    -> rx_done;
  endtask
endmodule // sefe_host_model

/* File: verif/sefe_spi_front_test.sv */
`timescale 1ns/1ps
`define SEFE_CHK(got, exp) \
  begin \
    compares++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("[FAIL] %0t got %h expected %h", $time, (got), (exp)); \
    end \
  end
// -----------------------------------------------------------------------------
// Self-checking bench of the serial front end
// -----------------------------------------------------------------------------
module sefe_spi_front_test;
  import sefe_pkg::*;
  // Short write cycle so the run stays brief; must exceed all in-cycle traffic.
  localparam int TWC = 600;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic sck, cs_n, hold_n, si, so, so_oe_n, busy, mem_we;
  logic [7:0] rd_addr, mem_waddr, mem_wdata;
  logic [7:0] rd_data = 8'h00;
  logic mem_ready = 1'b0;
  logic [7:0] mem [256];
  logic [15:0] exp_wr [$];
  logic [7:0] exp_rd [$];
  logic [15:0] want_wr;
  logic [7:0] want_rd;
  int mismatches = 0;
  int compares = 0;
  int busy_run = 0;

  always #5 clk = ~clk;

  sefe_spi_front #(.TWC_CYCLES(TWC)) dut (.i_core_clk(clk), .i_resetn(rstn), .i_sck(sck),
    .i_cs_n(cs_n), .i_hold_n(hold_n), .i_si(si), .o_so(so), .o_so_oe_n(so_oe_n),
    .o_write_busy_flag(busy), .o_rd_addr(rd_addr), .i_rd_data(rd_data), .o_mem_we(mem_we),
    .o_mem_waddr(mem_waddr), .o_mem_wdata(mem_wdata), .i_mem_ready(mem_ready));

  sefe_host_model host (.i_core_clk(clk), .i_so(so), .i_so_oe_n(so_oe_n), .o_sck(sck),
    .o_cs_n(cs_n), .o_hold_n(hold_n), .o_si(si));

  // Array model: data one cycle after the address, writes stalled at random.
  always @(posedge clk)
  begin
    #1;
    rd_data = mem[rd_addr];
    mem_ready = 1'($urandom);
  end

  // Each accepted array write must match the oldest expected write.
  always @(posedge clk)
    if (mem_we === 1'b1 && mem_ready)
    begin
      want_wr = exp_wr.size() ? exp_wr.pop_front() : 16'hxxxx;
      `SEFE_CHK({mem_waddr, mem_wdata}, want_wr)
      mem[mem_waddr] <= mem_wdata;
    end

  // A busy period lasts exactly the configured write cycle.
  always @(posedge clk)
    if (busy === 1'b1)
      busy_run++;
    else if (busy_run != 0)
    begin
      `SEFE_CHK(busy_run, TWC)
      busy_run = 0;
    end

  // Bytes the host reads back are compared when an expectation is queued.
  // The wait for the next edge lets the driver queue the note for this byte first.
  always @(host.rx_done)
  begin
    @(posedge clk);
    if (exp_rd.size() != 0)
    begin
      want_rd = exp_rd.pop_front();
      `SEFE_CHK(host.rx_byte, want_rd)
    end
  end

  task automatic tally_and_finish();
    if (mismatches == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Write frame; data wraps inside the 16-byte page.
  task automatic wr_frame(input logic [7:0] op, input logic [7:0] addr, input int n,
                          input bit commit);
    logic [7:0] d;
    host.open_frame();
    host.xfer(op, -1);
    host.xfer(addr, -1);
    for (int k = 0; k < n; k++)
    begin
      d = 8'($urandom);
      if (commit)
        exp_wr.push_back({addr[7:4], addr[3:0] + k[3:0], d});
      host.xfer(d, -1);
    end
    host.close_frame();
  endtask

  // Sequential read; the address rolls over from ff to 00.
  task automatic rd_frame(input logic [7:0] op, input logic [7:0] addr, input int n,
                          input int pause_at);
    host.open_frame();
    host.xfer(op, -1);
    host.xfer(addr, -1);
    for (int k = 0; k < n; k++)
    begin
      host.xfer(8'h00, (k == 1) ? pause_at : -1);
      exp_rd.push_back(mem[addr + k[7:0]]);
    end
    host.close_frame();
  endtask

  task automatic st_frame(input logic [7:0] exp);
    host.open_frame();
    host.xfer(SEFE_OP_READ_STATUS, -1);
    host.xfer(8'h00, -1);
    exp_rd.push_back(exp);
    host.close_frame();
  endtask

  // -----------------------------------------------------------------------------
  // Main sequence
  // -----------------------------------------------------------------------------
  initial
  begin
    void'($urandom(71114));
    foreach (mem[i])
      mem[i] = 8'($urandom);
    repeat (20) @(posedge clk);
    #1 rstn = 1'b1;
    `SEFE_CHK(so_oe_n, 1'b1)
    `SEFE_CHK(busy, 1'b0)
    repeat (3) @(posedge clk);
    wr_frame(SEFE_OP_WRITE, 8'h10, 1, 0);
    st_frame(8'h00);
    host.open_frame();
    host.xfer(8'h0e, -1);
    host.close_frame();
    st_frame(8'h02);
    wr_frame(SEFE_OP_WRITE, 8'h20, 33, 0);
    st_frame(8'h02);
    wr_frame(8'h0a, 8'h3e, 3, 1);
    `SEFE_CHK(busy, 1'b1)
    host.open_frame();
    host.xfer(SEFE_OP_READ, -1);
    host.xfer(8'h3e, -1);
    host.xfer(8'h00, -1);
    `SEFE_CHK(so_oe_n, 1'b1)
    host.close_frame();
    st_frame(8'h03);
    for (int t = 0; t < TWC && busy !== 1'b0; t++)
      @(posedge clk);
    #1;
    `SEFE_CHK(busy, 1'b0)
    st_frame(8'h00);
    rd_frame(8'h0b, 8'hfe, 3, 3);
    `SEFE_CHK(host.paused_oe, 1'b1)
    rd_frame(SEFE_OP_READ, 8'h3e, 2, -1);
    `SEFE_CHK(exp_wr.size(), 0)
    tally_and_finish();
  end

  // Watchdog well beyond the expected run of about 47 us.
  initial
  begin
    #500_000;
    mismatches++;
    tally_and_finish();
  end
endmodule // sefe_spi_front_test
